//--- logic/char_fifo.sv
// Sixteen-entry character FIFO with flush and occupancy count
`timescale 1ns/1ps
module char_fifo #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic                                  clk_i,
	input  wire logic                                  rst_i,
	// Control
	input  wire logic                                  flush_i,
	input  wire logic                                  push_i,
	input  wire logic [WIDTH-1:0]                      din_i,
	input  wire logic                                  pop_i,
	// Head and occupancy
	output logic      [WIDTH-1:0]                      dout_o,
	output logic      [fifo_ctrl_pkg::FIFO_AW:0]       count_o
);

	localparam int DEPTH = 1 << fifo_ctrl_pkg::FIFO_AW;

	logic [WIDTH-1:0]          mem [DEPTH];
	fifo_ctrl_pkg::fifo_ptr_t  p_q;
	fifo_ctrl_pkg::fifo_ptr_t  p_d;
	logic                      do_push;
	logic                      do_pop;

	// Refuse push when full and pop when empty
	assign do_push = push_i && (p_q.cnt != fifo_ctrl_pkg::FIFO_DEPTH);
	assign do_pop  = pop_i && (p_q.cnt != '0);

	// Pointer and count update; flush wins over traffic
	always_comb begin
		p_d = p_q;
		if (flush_i) begin
			p_d = '0;
		end else begin
			if (do_push) p_d.wr = p_q.wr + 1'b1;
			if (do_pop)  p_d.rd = p_q.rd + 1'b1;
			if (do_push && !do_pop) p_d.cnt = p_q.cnt + 1'b1;
			if (do_pop && !do_push) p_d.cnt = p_q.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) p_q <= '0;
		else       p_q <= p_d;
	end

	// Character storage
	always_ff @(posedge clk_i) begin
		if (do_push && !flush_i) mem[p_q.wr] <= din_i;
	end

	assign dout_o  = mem[p_q.rd];
	assign count_o = p_q.cnt;

endmodule : char_fifo

//--- logic/fifo_ctrl_pkg.sv
// Constants, field layouts and state types of the UART FIFO control block
package fifo_ctrl_pkg;

	// Register byte offsets on the Wishbone bus
	localparam logic [4:0] ADR_DATA   = 5'h00;
	localparam logic [4:0] ADR_CTRL   = 5'h04;
	localparam logic [4:0] ADR_STATUS = 5'h08;
	localparam logic [4:0] ADR_ISTAT  = 5'h0C;
	localparam logic [4:0] ADR_IMASK  = 5'h10;

	// Control register field positions
	localparam int CTRL_EN    = 0;
	localparam int CTRL_RXF   = 1;
	localparam int CTRL_TXF   = 2;
	localparam int CTRL_DMA   = 3;
	localparam int CTRL_THR_L = 6;

	// Status register field positions
	localparam int STAT_RXCNT   = 0;
	localparam int STAT_TXCNT   = 8;
	localparam int STAT_RXEMPTY = 16;
	localparam int STAT_RXFULL  = 17;
	localparam int STAT_TXEMPTY = 18;
	localparam int STAT_TXFULL  = 19;

	// Interrupt status bit positions
	localparam int EV_RX_TRIG  = 0;
	localparam int EV_TX_EMPTY = 1;
	localparam int EV_TIMEOUT  = 2;
	localparam int EV_OVERRUN  = 3;

	// FIFO geometry
	localparam int         FIFO_AW    = 4;
	localparam logic [4:0] FIFO_DEPTH = 5'h10;
	localparam logic [4:0] HOLD_DEPTH = 5'h01;

	// Receive trigger levels
	localparam logic [4:0] TRIG_LVL0 = 5'h01;
	localparam logic [4:0] TRIG_LVL1 = 5'h04;
	localparam logic [4:0] TRIG_LVL2 = 5'h08;
	localparam logic [4:0] TRIG_LVL3 = 5'h0E;

	// Reset values
	localparam logic [1:0] THR_RESET  = 2'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;

	// Pointers and occupancy of one FIFO
	typedef struct packed {
		logic [FIFO_AW-1:0] wr;
		logic [FIFO_AW-1:0] rd;
		logic [FIFO_AW:0]   cnt;
	} fifo_ptr_t;

	// Fields of the FIFO control register
	typedef struct packed {
		logic [1:0] thr;
		logic       dma;
		logic       txf;
		logic       rxf;
		logic       en;
	} fifo_control_t;

	// Complete state of the control block
	typedef struct packed {
		logic          ack;
		logic [31:0]   rdata;
		fifo_control_t ctrl;
		logic [3:0]    mask;
		logic [3:0]    istat;
		logic          irq;
		logic          tx_req_n;
		logic          rx_req_n;
		logic          rx_block;
		logic          rx_reached;
		logic          tx_empty;
		logic [7:0]    tx_char;
		logic          tx_char_valid;
	} ctrl_state_t;

endpackage : fifo_ctrl_pkg

//--- logic/uart_fifo_control.sv
// FIFO control, DMA request pins and register slave of one UART channel
`timescale 1ns/1ps
module uart_fifo_control (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Transmit shift register side
	input  wire logic        tx_load_req_i,
	output logic      [7:0]  tx_char_o,
	output logic             tx_char_valid_o,
	// Receive shift register side
	input  wire logic        rx_char_valid_i,
	input  wire logic [7:0]  rx_char_i,
	input  wire logic        rx_timeout_i,
	// DMA request pins and interrupt
	output logic             tx_transfer_request_n_o,
	output logic             rx_transfer_request_n_o,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	fifo_ctrl_pkg::ctrl_state_t q;
	fifo_ctrl_pkg::ctrl_state_t d;

	logic [7:0] tx_head;
	logic [7:0] rx_head;
	logic [4:0] tx_cnt;
	logic [4:0] rx_cnt;
	logic [4:0] cap;
	logic [4:0] trig;
	logic       access;
	logic       wr;
	logic       rd;
	logic       tx_push;
	logic       tx_pop;
	logic       rx_push;
	logic       rx_pop;
	logic       mode1;
	logic       reached;
	logic       ctrl_wr;
	logic       en_change;
	logic [3:0] events;
	logic       istat_rd;

	// Trigger level for a two-bit threshold code
	function automatic logic [4:0] trig_level(input logic [1:0] code);
		logic [4:0] lvl;
		lvl = fifo_ctrl_pkg::TRIG_LVL0;
		unique case (code)
			2'h0: lvl = fifo_ctrl_pkg::TRIG_LVL0;
			2'h1: lvl = fifo_ctrl_pkg::TRIG_LVL1;
			2'h2: lvl = fifo_ctrl_pkg::TRIG_LVL2;
			2'h3: lvl = fifo_ctrl_pkg::TRIG_LVL3;
		endcase
		return lvl;
	endfunction : trig_level

	////////////////////////////////////////////////////////////////////////
	// FIFOs

	// Transmit FIFO, drained by the shift register
	char_fifo #(
		.WIDTH   (8)
	) u_tx_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.flush_i (q.ctrl.txf),
		.push_i  (tx_push),
		.din_i   (wb_dat_i[7:0]),
		.pop_i   (tx_pop),
		.dout_o  (tx_head),
		.count_o (tx_cnt)
	);

	// Receive FIFO, filled by the shift register
	char_fifo #(
		.WIDTH   (8)
	) u_rx_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.flush_i (q.ctrl.rxf),
		.push_i  (rx_push),
		.din_i   (rx_char_i),
		.pop_i   (rx_pop),
		.dout_o  (rx_head),
		.count_o (rx_cnt)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode and data movement

	// One access per request; ack drops in the cycle after it rose
	assign access   = wb_cyc_i && wb_stb_i && !q.ack;
	assign wr       = access && wb_we_i && wb_sel_i[0];
	assign rd       = access && !wb_we_i;
	assign ctrl_wr  = wr && (wb_adr_i == fifo_ctrl_pkg::ADR_CTRL);
	assign istat_rd = rd && (wb_adr_i == fifo_ctrl_pkg::ADR_ISTAT);

	// Sixteen entries with FIFOs on, one holding slot with them off
	assign cap = q.ctrl.en ? fifo_ctrl_pkg::FIFO_DEPTH
	                       : fifo_ctrl_pkg::HOLD_DEPTH;

	// Character moves in and out
	assign tx_push = wr && (wb_adr_i == fifo_ctrl_pkg::ADR_DATA)
	                 && (tx_cnt < cap);
	assign rx_pop  = rd && (wb_adr_i == fifo_ctrl_pkg::ADR_DATA)
	                 && (rx_cnt != '0);
	assign tx_pop  = tx_load_req_i && (tx_cnt != '0)
	                 && !q.ctrl.txf;
	assign rx_push = rx_char_valid_i && (rx_cnt < cap);

	// Threshold and DMA mode
	assign trig    = trig_level(q.ctrl.thr);
	assign reached = rx_cnt >= trig;
	assign mode1   = q.ctrl.en && q.ctrl.dma;

	// Enable toggles flush both FIFOs
	assign en_change = ctrl_wr && (wb_dat_i[fifo_ctrl_pkg::CTRL_EN]
	                               != q.ctrl.en);

	// Interrupt events
	always_comb begin
		events = '0;
		events[fifo_ctrl_pkg::EV_RX_TRIG]  = reached && !q.rx_reached;
		events[fifo_ctrl_pkg::EV_TX_EMPTY] = (tx_cnt == '0) && !q.tx_empty;
		events[fifo_ctrl_pkg::EV_TIMEOUT]  = rx_timeout_i;
		events[fifo_ctrl_pkg::EV_OVERRUN]  = rx_char_valid_i && !rx_push;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	// All state updates of the block
	always_comb begin
		d = q;

		// Bus handshake
		d.ack = access;

		// Flush requests last exactly one cycle, then read back as zero
		d.ctrl.txf = 1'b0;
		d.ctrl.rxf = 1'b0;

		// Control register write
		if (ctrl_wr) begin
			d.ctrl.en = wb_dat_i[fifo_ctrl_pkg::CTRL_EN];
			if (wb_dat_i[fifo_ctrl_pkg::CTRL_EN]) begin
				d.ctrl.thr = wb_dat_i[fifo_ctrl_pkg::CTRL_THR_L +: 2];
				d.ctrl.dma = wb_dat_i[fifo_ctrl_pkg::CTRL_DMA];
				d.ctrl.txf = wb_dat_i[fifo_ctrl_pkg::CTRL_TXF];
				d.ctrl.rxf = wb_dat_i[fifo_ctrl_pkg::CTRL_RXF];
			end
			if (en_change) begin
				d.ctrl.txf = 1'b1;
				d.ctrl.rxf = 1'b1;
			end
		end

		// Interrupt mask register
		if (wr && (wb_adr_i == fifo_ctrl_pkg::ADR_IMASK)) begin
			d.mask = wb_dat_i[3:0];
		end

		// Sticky status: read clears, a new event in that cycle stays set
		d.istat = (istat_rd ? 4'h0 : q.istat) | events;
		d.irq   = |(d.istat & d.mask);

		// Edge trackers for the events
		d.rx_reached = reached;
		d.tx_empty   = (tx_cnt == '0);

		// Block-mode receive request: set at trigger or timeout, held
		if ((reached || rx_timeout_i) && (rx_cnt != '0)) begin
			d.rx_block = 1'b1;
		end else if (rx_cnt == '0) begin
			d.rx_block = 1'b0;
		end

		// Request pins
		if (mode1) begin
			d.tx_req_n = (tx_cnt == fifo_ctrl_pkg::FIFO_DEPTH);
			d.rx_req_n = !d.rx_block;
		end else begin
			d.tx_req_n = (tx_cnt != '0);
			d.rx_req_n = (rx_cnt == '0);
		end

		// Character handed to the transmit shift register
		d.tx_char_valid = tx_pop;
		if (tx_pop) d.tx_char = tx_head;

		// Read data
		d.rdata = '0;
		if (rd) begin
			unique case (wb_adr_i)
				fifo_ctrl_pkg::ADR_DATA: d.rdata[7:0] = rx_head;
				fifo_ctrl_pkg::ADR_CTRL: begin
					d.rdata[fifo_ctrl_pkg::CTRL_THR_L +: 2] = q.ctrl.thr;
					d.rdata[fifo_ctrl_pkg::CTRL_DMA] = q.ctrl.dma;
					d.rdata[fifo_ctrl_pkg::CTRL_TXF] = q.ctrl.txf;
					d.rdata[fifo_ctrl_pkg::CTRL_RXF] = q.ctrl.rxf;
					d.rdata[fifo_ctrl_pkg::CTRL_EN]  = q.ctrl.en;
					// Bits 5:4 stay zero
				end
				fifo_ctrl_pkg::ADR_STATUS: begin
					d.rdata[fifo_ctrl_pkg::STAT_RXCNT +: 5] = rx_cnt;
					d.rdata[fifo_ctrl_pkg::STAT_TXCNT +: 5] = tx_cnt;
					d.rdata[fifo_ctrl_pkg::STAT_RXEMPTY] = (rx_cnt == '0);
					d.rdata[fifo_ctrl_pkg::STAT_RXFULL]  = (rx_cnt == cap);
					d.rdata[fifo_ctrl_pkg::STAT_TXEMPTY] = (tx_cnt == '0);
					d.rdata[fifo_ctrl_pkg::STAT_TXFULL]  = (tx_cnt == cap);
				end
				fifo_ctrl_pkg::ADR_ISTAT: d.rdata[3:0] = q.istat;
				fifo_ctrl_pkg::ADR_IMASK: d.rdata[3:0] = q.mask;
				default:                  d.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// Reset puts FIFOs off, trigger at one, tx request active, rx request idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q               <= '0;
			q.ctrl.thr      <= fifo_ctrl_pkg::THR_RESET;
			q.mask          <= fifo_ctrl_pkg::MASK_RESET;
			q.tx_req_n      <= 1'b0;
			q.rx_req_n      <= 1'b1;
			q.tx_empty      <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// All outputs come straight from the state register
	assign wb_dat_o                = q.rdata;
	assign wb_ack_o                = q.ack;
	assign tx_char_o               = q.tx_char;
	assign tx_char_valid_o         = q.tx_char_valid;
	assign tx_transfer_request_n_o = q.tx_req_n;
	assign rx_transfer_request_n_o = q.rx_req_n;
	assign irq_o                   = q.irq;

endmodule : uart_fifo_control

//--- test/fifo_ctrl_properties.sv
// Port assertions for the UART FIFO control block
`timescale 1ns/1ps
module fifo_ctrl_properties (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Register bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Character side and pins
	input wire logic        tx_load_req_i,
	input wire logic        tx_char_valid_o,
	input wire logic        rx_char_valid_i,
	input wire logic        rx_timeout_i,
	input wire logic        tx_transfer_request_n_o,
	input wire logic        rx_transfer_request_n_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Write request on the bus
	logic wr_req;
	assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i;
	// Request waiting for its answer
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	chk_ack_answer: assert property (s_req |=> wb_ack_o)
		else $error("bus request not answered");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
		else $error("ack without request");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_reset_pins: assert property ($fell(rst_i) |-> !irq_o &&
		!tx_transfer_request_n_o && rx_transfer_request_n_o)
		else $error("pins wrong after reset");
	// Pins are registered from the counts: a write shows two edges later
	chk_tx_rise: assert property ($rose(tx_transfer_request_n_o)
		|-> $past(wr_req, 2) || $past(wr_req, 3))
		else $error("tx request rose without write");
	// A timeout acts on the next edge directly, a push through the count
	chk_rx_fall: assert property ($fell(rx_transfer_request_n_o)
		|-> $past(rx_char_valid_i, 2) || $past(rx_timeout_i) ||
		$past(rx_timeout_i, 2) || $past(wr_req, 2) || $past(wr_req, 3))
		else $error("rx request fell without cause");
	chk_txv_cause: assert property (tx_char_valid_o |->
		$past(tx_load_req_i))
		else $error("tx char without load request");
endmodule : fifo_ctrl_properties

bind uart_fifo_control fifo_ctrl_properties u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.tx_load_req_i(tx_load_req_i), .tx_char_valid_o(tx_char_valid_o),
	.rx_char_valid_i(rx_char_valid_i), .rx_timeout_i(rx_timeout_i),
	.tx_transfer_request_n_o(tx_transfer_request_n_o),
	.rx_transfer_request_n_o(rx_transfer_request_n_o), .irq_o(irq_o));

//--- test/shift_side_model.sv
// Shift register side model: drains tx characters, feeds rx characters
`timescale 1ns/1ps
module shift_side_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Commands from the bench
	input  wire logic       drain_i,
	input  wire logic       push_i,
	input  wire logic [7:0] push_char_i,
	input  wire logic       timeout_i,
	// Pins toward the block
	output logic            load_req_o,
	output logic            rx_valid_o,
	output logic [7:0]      rx_char_o,
	output logic            rx_timeout_o
);
	logic [1:0] div_q;
	// Slow drain, one request every fourth cycle; idle data keeps toggling
	always_ff @(posedge clk_i) begin
		div_q        <= rst_i ? 2'h0 : div_q + 2'h1;
		load_req_o   <= !rst_i && drain_i && div_q == 2'h0;
		rx_valid_o   <= !rst_i && push_i;
		rx_timeout_o <= !rst_i && timeout_i;
		rx_char_o    <= rst_i ? 8'h00 : push_i ? push_char_i : ~rx_char_o;
	end
endmodule : shift_side_model

//--- test/tb_top.sv
// Self-checking bench for the UART FIFO control block
`timescale 1ns/1ps
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        drain = 1'b0, push = 1'b0, tmo = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic [7:0]  pch = 8'h00, c;
	logic [31:0] dat = 32'h0, rdat, e, m;
	logic        ack, ldq, rxv, rxt, txv, txn, rxn, irq;
	logic [7:0]  rxc, txc;
	logic [31:0] exp_q[$], msk_q[$];
	logic [7:0]  tx_q[$];
	int          fail_count = 0, check_count = 0, lv[4];
	localparam logic [4:0] CT = fifo_ctrl_pkg::ADR_CTRL;
	localparam logic [4:0] ST = fifo_ctrl_pkg::ADR_STATUS;

	always #2.5 clk_i = ~clk_i;

	uart_fifo_control uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.tx_load_req_i(ldq), .tx_char_o(txc), .tx_char_valid_o(txv),
		.rx_char_valid_i(rxv), .rx_char_i(rxc), .rx_timeout_i(rxt),
		.tx_transfer_request_n_o(txn), .rx_transfer_request_n_o(rxn),
		.irq_o(irq));
	shift_side_model u_side (.clk_i(clk_i), .rst_i(rst_i), .drain_i(drain),
		.push_i(push), .push_char_i(pch), .timeout_i(tmo), .load_req_o(ldq),
		.rx_valid_o(rxv), .rx_char_o(rxc), .rx_timeout_o(rxt));

	task automatic cmp(input string n, input logic [31:0] ex, got);
		check_count++;
		if (got !== ex) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, ex, got);
		end
	endtask : cmp
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	// One classic bus cycle, held until ack
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			tally_and_finish();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic rd(input logic [4:0] a, input logic [31:0] ex, mk);
		exp_q.push_back(ex);
		msk_q.push_back(mk);
		wb(1'b0, a, 32'h0);
	endtask : rd
	task automatic pins(input logic t, r);
		repeat (3) @(posedge clk_i);
		cmp("tx_req_n", t, txn);
		cmp("rx_req_n", r, rxn);
	endtask : pins
	task automatic rxpush(input int n);
		repeat (n) begin
			push <= 1'b1;
			pch  <= 8'($urandom);
			@(posedge clk_i);
		end
		push <= 1'b0;
		@(posedge clk_i);
	endtask : rxpush
	task automatic txw(input int n);
		repeat (n) begin
			c = 8'($urandom);
			if (tx_q.size() < 16) tx_q.push_back(c);
			wb(1'b1, 5'h00, {24'h0, c});
		end
	endtask : txw
	task automatic drain_all();
		int n;
		drain <= 1'b1;
		for (n = 0; n < 300 && tx_q.size() > 0; n++) @(posedge clk_i);
		if (n >= 300) begin
			fail_count++;
			tally_and_finish();
		end
		drain <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : drain_all

	////////////////////////////////////////////////////////////////////////
	// Result watcher: oldest note against each read and tx character
	always @(posedge clk_i) begin
		if (ack === 1'b1 && !we && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			cmp("read data", e & m, rdat & m);
		end
		if (txv === 1'b1) begin
			if (tx_q.size() == 0) cmp("spare tx char", 0, 1);
			else cmp("tx char", tx_q.pop_front(), txc);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		lv = '{fifo_ctrl_pkg::TRIG_LVL0, fifo_ctrl_pkg::TRIG_LVL1,
			fifo_ctrl_pkg::TRIG_LVL2, fifo_ctrl_pkg::TRIG_LVL3};
		void'($urandom(32'h7A658837));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		pins(1'b0, 1'b1);
		rd(CT, 32'h0, 32'hFF);
		wb(1'b1, CT, 32'hC8);
		rd(CT, 32'h0, 32'hFF);
		rd(5'h14, 32'h0, 32'hFFFFFFFF);
		wb(1'b1, CT, 32'h01);
		txw(1);
		pins(1'b1, 1'b1);
		rxpush(1);
		pins(1'b1, 1'b0);
		rd(5'h00, {24'h0, pch}, 32'hFF);
		pins(1'b1, 1'b1);
		drain_all();
		pins(1'b0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, CT, {24'h0, 2'(i), 6'h0B});
			rd(CT, {24'h0, 2'(i), 6'h09}, 32'hFF);
			rxpush(lv[i] - 1);
			pins(1'b0, 1'b1);
			rxpush(1);
			pins(1'b0, 1'b0);
			cmp("irq masked", 1'b0, irq);
			rd(ST, lv[i], 32'h1F);
			wb(1'b1, fifo_ctrl_pkg::ADR_IMASK, 32'h1);
			repeat (2) @(posedge clk_i);
			cmp("irq", 1'b1, irq);
			rd(fifo_ctrl_pkg::ADR_ISTAT, 32'h1, 32'h1);
			repeat (2) @(posedge clk_i);
			cmp("irq cleared", 1'b0, irq);
			wb(1'b1, fifo_ctrl_pkg::ADR_IMASK, 32'h0);
		end
		wb(1'b1, CT, 32'hCB);
		pins(1'b0, 1'b1);
		rxpush(1);
		tmo <= 1'b1;
		@(posedge clk_i);
		tmo <= 1'b0;
		pins(1'b0, 1'b0);
		txw(17);
		pins(1'b1, 1'b0);
		rd(ST, 32'h1000, 32'h1F00);
		wb(1'b1, CT, 32'hCD);
		tx_q.delete();
		rd(ST, 32'h0, 32'h1F00);
		pins(1'b0, 1'b0);
		// Block mode rx request only returns high once the FIFO is empty
		rd(5'h00, {24'h0, pch}, 32'hFF);
		pins(1'b0, 1'b1);
		txw(3);
		drain_all();
		tally_and_finish();
	end
endmodule : tb_top
